/* File: hw/scm_pkg.sv */
// package: register map, field layout, timing and mode types for clock control
`default_nettype none
package scm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SYS_CLK_CTRL_OFS  = 12'h000;
    localparam logic [11:0] FAST_OSC_CTRL_OFS = 12'h004;
    localparam logic [11:0] HALT_CTRL_OFS     = 12'h008;
    localparam logic [11:0] MODE_STATUS_OFS   = 12'h00C;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SEL_MSB        = 7;
    localparam int SEL_LSB        = 5;
    localparam int FAST_KEEP_BIT  = 1;
    localparam int SLOW_KEEP_BIT  = 0;
    localparam int STABLE_BIT     = 1;
    localparam int FAST_EN_BIT    = 0;
    localparam int HALT_BIT       = 0;
    localparam int WAKE_BIT       = 1;
    localparam int WDOG_EN_BIT    = 2;
    localparam int PD_CLR_BIT     = 3;
    localparam int STATUS_PD_BIT  = 4;
    localparam int STATUS_TMO_BIT = 5;
    localparam logic [7:0] SYS_CLK_CTRL_RST  = 8'h00;
    localparam logic       FAST_EN_RST       = 1'b1;
    localparam logic [2:0] SEL_SLOW          = 3'h7;
    // ------------------------------------------------------------
    // oscillators and timing
    // ------------------------------------------------------------
    localparam int REF_CLK_HZ          = 100_000_000;
    localparam int FAST_OSC_HZ         = 8_000_000;
    localparam int SLOW_OSC_HZ         = 32_000;
    localparam int FAST_STABLE_US      = 16;
    localparam int FAST_STABLE_CYC     =
        (FAST_STABLE_US * (REF_CLK_HZ / 1_000_000));
    localparam int FAST_HALF_CYC       = REF_CLK_HZ / (2 * FAST_OSC_HZ);
    localparam int SLOW_HALF_CYC       = REF_CLK_HZ / (2 * SLOW_OSC_HZ);
    localparam int WDOG_W              = 16;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_FAST, MODE_SLOW, MODE_SLEEP,
        MODE_STBY_LOW, MODE_STBY_BOTH, MODE_STBY_HIGH
    } scm_mode_t;
    typedef struct packed {
        logic cpuClk;
        logic sysClk;
        logic highSpeedClock;
        logic lowSpeedClock;
        logic slowOscClock;
    } scm_clocks_t;
endpackage
`default_nettype wire

/* File: hw/scm_clock_control.sv */
// system clock selection and operating-mode control with apb registers
`default_nettype none
module scm_clock_control
    import scm_pkg::*;
#(
    parameter int STABLE_CYC = FAST_STABLE_CYC,
    parameter int FAST_HALF  = FAST_HALF_CYC,
    parameter int SLOW_HALF  = SLOW_HALF_CYC
) (
    input  wire  logic        ref_clk,
    input  wire  logic        rst,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [11:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire  logic        haltReq,
    input  wire  logic        wakeReq,
    output scm_clocks_t       clocks,
    output scm_mode_t         mode,
    output logic              watchdogClear,
    output logic [WDOG_W-1:0] watchdogCount
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0]  sysClkSelect;
    logic        fastOscHaltKeep;
    logic        slowOscHaltKeep;
    logic        fastOscEnable;
    logic        fastOscStableFlag;
    logic        watchdogEnable;
    logic        powerDownFlag;
    logic        watchdogTimeoutFlag;
    logic        halted;
    logic        keepFastLatched;
    logic        keepSlowLatched;
    logic [31:0] stableCnt;
    logic [15:0] fastCnt;
    logic [15:0] slowCnt;
    logic        fastRaw;
    logic        slowRaw;
    logic [6:0]  divCnt;
    logic        curSlow;
    logic [2:0]  curSel;
    logic        sysRaw;
    logic        targetRaw;
    logic        wrEn;
    logic        rdEn;
    logic        addrOk;
    logic        fastRun;
    logic        slowRun;
    logic        haltGo;
    logic        wdogTick;
    logic        slowPrev;

    assign wrEn   = psel & penable & pwrite;
    assign rdEn   = psel & penable & ~pwrite;
    assign addrOk = (paddr == SYS_CLK_CTRL_OFS) ||
                    (paddr == FAST_OSC_CTRL_OFS) ||
                    (paddr == HALT_CTRL_OFS) ||
                    (paddr == MODE_STATUS_OFS);
    assign pready = 1'b1;
    assign haltGo = ~halted & (haltReq |
        (wrEn && paddr == HALT_CTRL_OFS && pwdata[HALT_BIT]));

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sysClkSelect    <= SYS_CLK_CTRL_RST[SEL_MSB:SEL_LSB];
            fastOscHaltKeep <= SYS_CLK_CTRL_RST[FAST_KEEP_BIT];
            slowOscHaltKeep <= SYS_CLK_CTRL_RST[SLOW_KEEP_BIT];
            fastOscEnable   <= FAST_EN_RST;
            watchdogEnable  <= 1'b0;
        end else if (wrEn) begin
            if (paddr == SYS_CLK_CTRL_OFS) begin
                sysClkSelect    <= pwdata[SEL_MSB:SEL_LSB];
                fastOscHaltKeep <= pwdata[FAST_KEEP_BIT];
                slowOscHaltKeep <= pwdata[SLOW_KEEP_BIT];
            end
            if (paddr == FAST_OSC_CTRL_OFS)
                fastOscEnable <= pwdata[FAST_EN_BIT];
            if (paddr == HALT_CTRL_OFS)
                watchdogEnable <= pwdata[WDOG_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    SYS_CLK_CTRL_OFS: begin
                        prdata[SEL_MSB:SEL_LSB] <= sysClkSelect;
                        prdata[FAST_KEEP_BIT]   <= fastOscHaltKeep;
                        prdata[SLOW_KEEP_BIT]   <= slowOscHaltKeep;
                    end
                    FAST_OSC_CTRL_OFS: begin
                        prdata[STABLE_BIT]  <= fastOscStableFlag;
                        prdata[FAST_EN_BIT] <= fastOscEnable;
                    end
                    HALT_CTRL_OFS: begin
                        prdata[HALT_BIT]    <= halted;
                        prdata[WDOG_EN_BIT] <= watchdogEnable;
                    end
                    MODE_STATUS_OFS: begin
                        prdata[2:0] <= mode;
                        prdata[STATUS_PD_BIT]  <= powerDownFlag;
                        prdata[STATUS_TMO_BIT] <= watchdogTimeoutFlag;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            if ((wrEn | rdEn) & ~addrOk)
                pslverr <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // halt and mode
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            halted          <= 1'b0;
            keepFastLatched <= 1'b0;
            keepSlowLatched <= 1'b0;
        end else if (haltGo) begin
            halted          <= 1'b1;
            keepFastLatched <= fastOscHaltKeep;
            keepSlowLatched <= slowOscHaltKeep;
        end else if (halted & (wakeReq |
            (wrEn && paddr == HALT_CTRL_OFS && pwdata[WAKE_BIT]))) begin
            halted <= 1'b0;
        end
    end

    always_comb begin
        if (!halted)
            mode = (curSlow) ? MODE_SLOW : MODE_FAST;
        else begin
            unique case ({keepFastLatched, keepSlowLatched})
                2'b00: mode = MODE_SLEEP;
                2'b01: mode = MODE_STBY_LOW;
                2'b11: mode = MODE_STBY_BOTH;
                2'b10: mode = MODE_STBY_HIGH;
            endcase
        end
    end

    // a pending fast code starts the oscillator, else the switch never ends
    assign fastRun = (mode == MODE_FAST) |
        ((mode == MODE_SLOW) & (fastOscEnable |
        (sysClkSelect != SEL_SLOW))) |
        (mode == MODE_STBY_HIGH) | (mode == MODE_STBY_BOTH);
    assign slowRun = (mode != MODE_SLEEP) | watchdogEnable;

    // ------------------------------------------------------------
    // oscillators, modelled as dividers of ref_clk
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fastCnt <= 16'h0000;
            fastRaw <= 1'b0;
        end else if (!fastRun) begin
            fastCnt <= 16'h0000;
            fastRaw <= 1'b0;
        end else if (fastCnt == 16'(FAST_HALF - 1)) begin
            fastCnt <= 16'h0000;
            fastRaw <= ~fastRaw;
        end else
            fastCnt <= fastCnt + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slowCnt <= 16'h0000;
            slowRaw <= 1'b0;
        end else if (!slowRun) begin
            slowCnt <= 16'h0000;
            slowRaw <= 1'b0;
        end else if (slowCnt == 16'(SLOW_HALF - 1)) begin
            slowCnt <= 16'h0000;
            slowRaw <= ~slowRaw;
        end else
            slowCnt <= slowCnt + 16'h0001;
    end

    // stable flag drops whenever the oscillator is off, then counts up
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stableCnt         <= 32'h0000_0000;
            fastOscStableFlag <= 1'b0;
        end else if (!fastRun) begin
            stableCnt         <= 32'h0000_0000;
            fastOscStableFlag <= 1'b0;
        end else if (stableCnt == 32'(STABLE_CYC - 1)) begin
            fastOscStableFlag <= 1'b1;
        end else
            stableCnt <= stableCnt + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // divider and glitch-free selector
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst)
            divCnt <= 7'h00;
        else if (fastRun & fastCnt == 16'(FAST_HALF - 1) & fastRaw)
            divCnt <= divCnt + 7'h01;
    end

    always_comb begin
        if (sysClkSelect == SEL_SLOW)
            targetRaw = slowRaw;
        else if (sysClkSelect == 3'h0)
            targetRaw = fastRaw;
        else
            targetRaw = divCnt[sysClkSelect - 3'h1];
    end

    // switch only while old and new clock are both low, so no runt pulse;
    // the wait can reach a period of the slower one, accepted trade-off
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            curSel  <= 3'h0;
            curSlow <= 1'b0;
        end else if (!sysRaw && !targetRaw &&
            curSel != sysClkSelect) begin
            if (sysClkSelect == SEL_SLOW) begin
                curSel  <= sysClkSelect;
                curSlow <= 1'b1;
            end else if (fastOscStableFlag) begin
                curSel  <= sysClkSelect;
                curSlow <= 1'b0;
            end
        end
    end

    always_comb begin
        if (curSlow)
            sysRaw = slowRaw;
        else if (curSel == 3'h0)
            sysRaw = fastRaw;
        else
            sysRaw = divCnt[curSel - 3'h1];
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            clocks <= '0;
        else begin
            clocks.cpuClk         <= sysRaw & ~halted;
            clocks.sysClk         <= sysRaw & (~halted |
                (mode == MODE_STBY_BOTH) |
                ((mode == MODE_STBY_LOW) & curSlow) |
                ((mode == MODE_STBY_HIGH) & ~curSlow));
            clocks.highSpeedClock <= fastRaw & fastRun;
            clocks.lowSpeedClock  <= slowRaw & (mode != MODE_SLEEP) &
                (mode != MODE_STBY_HIGH);
            clocks.slowOscClock   <= slowRaw & slowRun;
        end
    end

    // ------------------------------------------------------------
    // power-down flag and watchdog
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        slowPrev <= rst ? 1'b0 : slowRaw;
    end
    assign wdogTick = slowRaw & ~slowPrev & watchdogEnable;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            powerDownFlag       <= 1'b0;
            watchdogTimeoutFlag <= 1'b0;
            watchdogCount       <= '0;
            watchdogClear       <= 1'b0;
        end else begin
            watchdogClear <= haltGo;
            if (haltGo) begin
                powerDownFlag       <= 1'b1;
                watchdogTimeoutFlag <= 1'b0;
                watchdogCount       <= '0;
            end else begin
                if (wrEn && paddr == HALT_CTRL_OFS && pwdata[PD_CLR_BIT])
                    powerDownFlag <= 1'b0;
                if (wdogTick) begin
                    watchdogCount <= watchdogCount + WDOG_W'(1);
                    if (&watchdogCount)
                        watchdogTimeoutFlag <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/scm_clock_control_sva.sv */
// checker: port-level assertions for the clock and mode controller
`default_nettype none
module scm_clock_control_sva
    import scm_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        haltReq,
    input wire scm_clocks_t clocks,
    input wire scm_mode_t   mode,
    input wire logic        watchdogClear
);
    // ----------------------------------------------------------
    // shadow of written control bits, seen from the bus side
    // ----------------------------------------------------------
    logic       wr;
    logic       run;
    logic       wdEn;
    logic [7:0] sysCtrl;
    assign wr  = psel && penable && pwrite;
    assign run = (mode == MODE_FAST) || (mode == MODE_SLOW);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sysCtrl <= 8'h00;
        end else if (wr && paddr == SYS_CLK_CTRL_OFS) begin
            sysCtrl <= pwdata[7:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdEn <= 1'h0;
        end else if (wr && paddr == HALT_CTRL_OFS) begin
            wdEn <= pwdata[WDOG_EN_BIT];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // gating checks wait 8 cycles: a clean stop may finish a phase first
    a_mode_legal: assert property (mode <= MODE_STBY_HIGH)
        else $error("mode outside the six legal values");
    a_halt_sleep: assert property (
        haltReq && run && sysCtrl[1:0] == 2'h0 |=> mode == MODE_SLEEP)
        else $error("halt with no keep bits missed sleep");
    a_halt_low: assert property (
        haltReq && run && sysCtrl[1:0] == 2'h1 |=> mode == MODE_STBY_LOW)
        else $error("halt with slow keep missed standby low");
    a_halt_both: assert property (
        haltReq && run && sysCtrl[1:0] == 2'h3 |=> mode == MODE_STBY_BOTH)
        else $error("halt with both keeps missed standby both");
    a_halt_high: assert property (
        haltReq && run && sysCtrl[1:0] == 2'h2 |=> mode == MODE_STBY_HIGH)
        else $error("halt with fast keep missed standby high");
    a_wdog_clear: assert property (
        haltReq && run |-> ##[1:2] watchdogClear)
        else $error("halt gave no watchdog clear pulse");
    a_cpu_gated: assert property (
        !run && !$past(run, 8) && sysCtrl[7:5] == 3'h0 |-> !clocks.cpuClk)
        else $error("cpu clock runs while halted");
    a_sleep_stop: assert property (
        mode == MODE_SLEEP && $past(mode, 8) == MODE_SLEEP
        |-> !(clocks.highSpeedClock || clocks.lowSpeedClock
        || clocks.sysClk))
        else $error("clock running in sleep");
    a_sleep_osc: assert property (
        mode == MODE_SLEEP && $past(mode, 8) == MODE_SLEEP && !wdEn
        |-> !clocks.slowOscClock)
        else $error("slow oscillator runs in sleep without watchdog");
    a_low_gated: assert property (
        mode == MODE_STBY_LOW && $past(mode, 8) == MODE_STBY_LOW
        |-> !clocks.highSpeedClock)
        else $error("high speed clock runs in standby low");
    a_high_gated: assert property (
        mode == MODE_STBY_HIGH && $past(mode, 8) == MODE_STBY_HIGH
        |-> !clocks.lowSpeedClock)
        else $error("low speed clock runs in standby high");
    a_err_unmapped: assert property (
        psel && penable && paddr > MODE_STATUS_OFS |=> pslverr)
        else $error("unmapped access gave no slave error");
endmodule
bind scm_clock_control scm_clock_control_sva chk_u (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .haltReq(haltReq), .clocks(clocks), .mode(mode),
    .watchdogClear(watchdogClear)
);
`default_nettype wire

/* File: verif/test_scm_clock_control.sv */
// testbench: registers and clock division over apb, halt modes via haltReq and wakeReq pins
`default_nettype none
module test_scm_clock_control
    import scm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------
    // signals, design and clock
    // ----------------------------------------------------------
    localparam int FH = 6;
    localparam int SH = 4;
    logic              ref_clk, rst, psel, penable, pwrite, pready;
    logic              pslverr, haltReq, wakeReq, wdClr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [4:0]        act;
    logic [WDOG_W-1:0] wdCnt;
    scm_clocks_t       clocks;
    scm_mode_t         mode;
    scm_mode_t         expMode [4] = '{MODE_SLEEP, MODE_STBY_LOW,
                                       MODE_STBY_HIGH, MODE_STBY_BOTH};
    int                n_errors = 0, checks_done = 0, cyc = 0, per;
    scm_clock_control #(.STABLE_CYC(8), .FAST_HALF(FH), .SLOW_HALF(SH))
    dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .haltReq(haltReq),
        .wakeReq(wakeReq), .clocks(clocks), .mode(mode),
        .watchdogClear(wdClr), .watchdogCount(wdCnt));
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // longest run is near 14000 cycles; nearly triple it for the ceiling
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic pulse(input logic h);
        @(posedge ref_clk);
        haltReq <= h;
        wakeReq <= !h;
        @(posedge ref_clk);
        haltReq <= 1'h0;
        wakeReq <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask
    // marks which clocks toggle; settle first so a final stop is not seen
    task automatic watch;
        logic [4:0] p;
        repeat (8) @(posedge ref_clk);
        p = clocks;
        act = 5'h00;
        repeat (48) begin
            @(posedge ref_clk);
            act = act | (clocks ^ p);
            p = clocks;
        end
    endtask
    // let the selector finish its switch, then time the 2nd to 3rd rise
    task automatic measure;
        logic p;
        int   k;
        repeat (1000) @(posedge ref_clk);
        p = clocks.sysClk;
        k = 0;
        per = 0;
        repeat (4000) begin
            @(posedge ref_clk);
            per++;
            if (clocks.sysClk && !p) begin
                k++;
                if (k == 3) break;
                per = 0;
            end
            p = clocks.sysClk;
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    initial begin
        int i, k;
        rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h000; pwdata = 32'h0; haltReq = 1'h0; wakeReq = 1'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        apb(1'h0, SYS_CLK_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        watch;
        chk(act, 5'h1F);
        apb(1'h1, SYS_CLK_CTRL_OFS, 32'hFFFFFFFF);
        apb(1'h0, SYS_CLK_CTRL_OFS, 32'h0);
        chk(rd, 32'hE3);
        apb(1'h1, FAST_OSC_CTRL_OFS, 32'h0);
        watch;
        chk({29'h0, mode}, 32'(MODE_SLOW));
        chk(act, 5'h1B);
        apb(1'h1, FAST_OSC_CTRL_OFS, 32'h1);
        apb(1'h0, FAST_OSC_CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        repeat (16) @(posedge ref_clk);
        apb(1'h0, FAST_OSC_CTRL_OFS, 32'h0);
        chk(rd, 32'h3);
        $display("end of register test");
        for (i = 0; i < 8; i++) begin
            apb(1'h1, SYS_CLK_CTRL_OFS, 32'(i << 5));
            measure;
            chk(32'(per), 32'(i == 7 ? 2 * SH : (2 * FH) << i));
        end
        apb(1'h1, SYS_CLK_CTRL_OFS, 32'h0);
        measure;
        chk(32'(per), 32'(2 * FH));
        $display("end of division test");
        for (i = 0; i < 5; i++) begin
            k = i % 4;
            apb(1'h1, HALT_CTRL_OFS, i == 4 ? 32'h4 : 32'h0);
            apb(1'h1, SYS_CLK_CTRL_OFS, 32'(k));
            pulse(1'h1);
            chk({29'h0, mode}, 32'(expMode[k]));
            apb(1'h0, MODE_STATUS_OFS, 32'h0);
            chk(rd[5:4], 32'h1);
            watch;
            chk(act, {1'h0, k[1], k[1], k[0], k != 0 || i == 4});
            if (i == 0) chk(wdCnt, 32'h0);
            if (i == 4) chk(32'(wdCnt != 16'h0000), 32'h1);
            pulse(1'h0);
            chk({29'h0, mode}, 32'(MODE_FAST));
            apb(1'h1, HALT_CTRL_OFS, 32'h8);
        end
        apb(1'h0, MODE_STATUS_OFS, 32'h0);
        chk(rd[4], 32'h0);
        $display("end of halt test");
        apb(1'h1, 12'h010, 32'hFFFFFFFF);
        apb(1'h0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        @(posedge ref_clk);
        chk(pslverr, 32'h1);
        apb(1'h0, SYS_CLK_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("end of unmapped test");
        test_done();
    end
endmodule
`default_nettype wire
